// File: verif/emm_feeder.sv
// Partner: surrounding logic feeding random operands, signs and enable
`timescale 1ns/1ps
module emm_feeder (
  input  wire        pclk,
  input  wire        run,
  output reg  [17:0] data_a,
  output reg  [17:0] data_b,
  output reg         sign_a,
  output reg         sign_b,
  output reg         mul_ce
);
  integer seed = 29647;
  initial {mul_ce, sign_b, sign_a, data_b, data_a} = 39'h0;
  // One sign per side serves both narrow halves; no summing here
  always @(posedge pclk) begin
    if (run) begin
      data_a <= 18'($random(seed));
      data_b <= 18'($random(seed));
      {sign_a, sign_b} <= 2'($random(seed));
      mul_ce <= 2'($random(seed)) != 2'b00;
    end
  end
endmodule

// File: verif/emm_properties.sv
// Checker: product timing, sign, hold and register bus response
`timescale 1ns/1ps
module emm_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        mul_ce,
  input wire [17:0] data_a,
  input wire [17:0] data_b,
  input wire        sign_a,
  input wire        sign_b,
  input wire [35:0] product,
  input wire        product_signed
);
  reg  [8:0]         ctl_q;
  reg                wok_q;
  reg  [17:0]        a_q;
  wire               wr = psel & penable & pready & pwrite;
  wire               ok = mul_ce & !wr & wok_q;
  wire signed [18:0] xb = {sign_b & data_b[17], data_b};
  wire signed [37:0] pw = $signed({sign_a & data_a[17], data_a}) * xb;
  wire signed [37:0] pr = $signed({sign_a & a_q[17], a_q}) * xb;
  wire signed [19:0] n0 = $signed({sign_a & data_a[8], data_a[8:0]})
                        * $signed({sign_b & data_b[8], data_b[8:0]});
  wire signed [19:0] n1 = $signed({sign_a & data_a[17], data_a[17:9]})
                        * $signed({sign_b & data_b[17], data_b[17:9]});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 9'h000;
      wok_q <= 1'b1;
      a_q   <= 18'h00000;
    end else begin
      if (mul_ce) a_q <= data_a;
      if (wr && paddr == 12'h000) ctl_q <= pwdata[8:0];
      if (wr && paddr == 12'h004) wok_q <= pwdata[4:0] >= 5'h12 && pwdata[12:8] >= 5'h12;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wide_prod_a: assert property (ok && ctl_q == 9'h000 |=> product == $past(pw[35:0]))
    else $error("wide product wrong");
  stage_a_a: assert property ((ok && ctl_q == 9'h002) [*2] |=> product == $past(pr[35:0]))
    else $error("registered operand latency wrong");
  narrow_low_a: assert property (ok && ctl_q == 9'h001 |=> product[17:0] == $past(n0[17:0]))
    else $error("narrow low product wrong");
  narrow_high_a: assert property (ok && ctl_q == 9'h001 |=> product[35:18] == $past(n1[17:0]))
    else $error("narrow high product wrong");
  sign_out_a: assert property (ok && (ctl_q & 9'h1E0) == 9'h000
    |=> product_signed == $past(sign_a | sign_b)) else $error("product sign wrong");
  ce_hold_a: assert property (!mul_ce |=> $stable(product) && $stable(product_signed))
    else $error("product moved without enable");
  bus_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("wait state count wrong");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  err_map_a: assert property (pready |-> pslverr == (paddr > 12'h00C || paddr[1:0] != 2'b00))
    else $error("error response wrong");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data not idle");
  cover property (ok && ctl_q == 9'h001);
  cover property (ok && ctl_q == 9'h000 && sign_a && sign_b);
  cover property (pready && pslverr);
endmodule
bind emm_top emm_props u_emm_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mul_ce(mul_ce), .data_a(data_a), .data_b(data_b), .sign_a(sign_a), .sign_b(sign_b),
  .product(product), .product_signed(product_signed));

// File: verif/emm_tb.sv
// Testbench: bus setup, random operands, model compared with products
`timescale 1ns/1ps
module tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         run = 1'b0;
  reg         hold = 1'b1;
  wire [31:0] prdata;
  wire        pready, pslverr, mul_ce, sign_a, sign_b, product_signed;
  wire [17:0] data_a, data_b;
  wire [35:0] product;
  reg  [37:0] h[0:2];
  reg  [36:0] ex;
  reg  [8:0]  cfg = 9'h000;
  reg  [31:0] rd;
  reg         er;
  int         wa = 18, wb = 18, fill = 0, fail_count = 0, n_compared = 0;
  int         cf[8] = '{32'h1212_0000, 32'h0A0A_0000, 32'h1212_0002, 32'h0E12_0008,
                        32'h1212_01FE, 32'h1212_0001, 32'h1212_01FF, 32'h1212_0123};
  emm_top u_emm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mul_ce(mul_ce), .data_a(data_a), .data_b(data_b), .sign_a(sign_a),
    .sign_b(sign_b), .product(product), .product_signed(product_signed));
  emm_feeder u_emm_feeder (.pclk(pclk), .run(run), .data_a(data_a), .data_b(data_b),
    .sign_a(sign_a), .sign_b(sign_b), .mul_ce(mul_ce));
  initial forever #4 pclk = ~pclk;
  task check(input [36:0] s, input [36:0] e, input string n);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fail_count++;
  endtask
  function longint ext(input [17:0] v, input int w, input s);
    ext = v & ((64'h1 << w) - 1);
    if (s && v[w-1]) ext -= 64'h1 << w;
  endfunction
  function int b(int n);
    return cfg[n];
  endfunction
  // Operand history, frozen with the enable like the stages
  always @(posedge pclk) begin
    if (mul_ce) begin
      h[2] <= h[1];
      h[1] <= h[0];
      h[0] <= {sign_a, sign_b, data_a, data_b};
      fill <= fill + 1;
    end
  end
  always @(negedge pclk) begin : cmp
    int j, ia, ib;
    reg sa, sb;
    if (!hold && fill >= 3) begin
      ex = 37'h0;
      for (int k = 0; k < 2; k++) begin
        j = k & b(0);
        ia = b(1 + j) + b(7 + j);
        ib = b(3 + j) + b(7 + j);
        sa = h[b(5) + b(7 + j)][37];
        sb = h[b(6) + b(7 + j)][36];
        if (b(0)) ex[18*k +: 18] = 18'(ext(h[ia][18+9*k +: 9], 9, sa) * ext(h[ib][9*k +: 9], 9, sb));
        else if (k == 0) ex[35:0] = 36'(ext(h[ia][35:18], wa, sa) * ext(h[ib][17:0], wb, sb));
      end
      ex[36] = h[b(5) + b(7)][37] | h[b(6) + b(7)][36];
      check({product_signed, product}, ex, "product");
    end
  end
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0, "ctrl");
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h1212, "width");
    apb(1'b0, 12'h010, 32'h0);
    check({er, rd}, 33'h1_0000_0000, "unmapped");
    run <= 1'b1;
    foreach (cf[i]) begin
      hold = 1'b1;
      apb(1'b1, 12'h000, cf[i][15:0]);
      apb(1'b1, 12'h004, cf[i][31:16]);
      cfg = cf[i][8:0];
      wa = cf[i][20:16];
      wb = cf[i][28:24];
      @(negedge pclk);
      fill = 0;
      hold = 1'b0;
      repeat (200) @(posedge pclk);
    end
    run <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, ex[31:0], "prod low");
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, ex[36:32], "prod high");
    give_verdict;
  end
endmodule

// File: verilog/emm_consts.vh
// Constants for the dual-mode embedded multiplier block
`ifndef EMM_CONSTS_VH
`define EMM_CONSTS_VH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define EMM_OFS_CTRL   12'h000
`define EMM_OFS_WIDTH  12'h004
`define EMM_OFS_PROD_L 12'h008
`define EMM_OFS_PROD_H 12'h00C

// ***************************************************************
// Control register fields
// ***************************************************************
`define EMM_CTRL_MODE  0
`define EMM_CTRL_AREG  2:1
`define EMM_CTRL_BREG  4:3
`define EMM_CTRL_SREG  6:5
`define EMM_CTRL_OREG  8:7
`define EMM_CTRL_BITS  9
`define EMM_CTRL_RST   9'h000

// ***************************************************************
// Width register fields
// ***************************************************************
`define EMM_WID_A      4:0
`define EMM_WID_B      12:8
`define EMM_WID_RST    5'h12
`define EMM_WID_MIN    5'h0A
`define EMM_WID_MAX    5'h12

// ***************************************************************
// Mode codes and datapath sizes
// ***************************************************************
`define EMM_MODE_WIDE   1'b0
`define EMM_MODE_NARROW 1'b1
`define EMM_HALF_W      9
`define EMM_FULL_W      18
`define EMM_PROD_W      36
`define EMM_HPROD_W     18

`endif

// File: verilog/emm_stage.v
// Optional register stage with bypass, shared clock, enable and clear
`timescale 1ns/1ps
module emm_stage #(
  parameter W = 9
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         ce,
  input  wire         use_reg,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] stage_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_q <= {W{1'b0}};
    end else if (ce) begin
      stage_q <= d;
    end
  end

  assign q = use_reg ? stage_q : d;
endmodule

// File: verilog/emm_top.v
// Dual-mode embedded multiplier with APB configuration and product readback
`timescale 1ns/1ps
`include "emm_consts.vh"
module emm_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        mul_ce,
  input  wire [17:0] data_a,
  input  wire [17:0] data_b,
  input  wire        sign_a,
  input  wire        sign_b,
  output wire [35:0] product,
  output wire        product_signed
);
  // ***************************************************************
  // APB slave
  // ***************************************************************
  reg [`EMM_CTRL_BITS-1:0] ctrl_q;
  reg [4:0]                wid_a_q;
  reg [4:0]                wid_b_q;
  reg [31:0]               prdata_q;
  reg                      pready_q;
  reg                      pslverr_q;
  reg [35:0]               prod_q;
  reg                      psgn_q;
  reg [31:0]               rd_d;
  reg                      hit_d;

  wire acc   = psel & penable;
  wire wr_go = acc & pready_q & pwrite;

  always @* begin
    rd_d  = 32'h00000000;
    hit_d = 1'b1;
    case (paddr)
      `EMM_OFS_CTRL:   rd_d = {23'h000000, ctrl_q};
      `EMM_OFS_WIDTH:  rd_d = {19'h00000, wid_b_q, 3'h0, wid_a_q};
      `EMM_OFS_PROD_L: rd_d = prod_q[31:0];
      `EMM_OFS_PROD_H: rd_d = {27'h0000000, psgn_q, prod_q[35:32]};
      default:         hit_d = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc & ~pready_q;
      prdata_q  <= (acc & ~pready_q & ~pwrite) ? rd_d : 32'h00000000;
      pslverr_q <= acc & ~pready_q & ~hit_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `EMM_CTRL_RST;
      wid_a_q <= `EMM_WID_RST;
      wid_b_q <= `EMM_WID_RST;
    end else if (wr_go) begin
      if (paddr == `EMM_OFS_CTRL) begin
        ctrl_q <= pwdata[`EMM_CTRL_BITS-1:0];
      end
      if (paddr == `EMM_OFS_WIDTH) begin
        wid_a_q <= pwdata[`EMM_WID_A];
        wid_b_q <= pwdata[`EMM_WID_B];
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ***************************************************************
  // Mode and stage selection
  // ***************************************************************
  wire       narrow = ctrl_q[`EMM_CTRL_MODE] == `EMM_MODE_NARROW;
  wire [1:0] areg   = ctrl_q[`EMM_CTRL_AREG];
  wire [1:0] breg   = ctrl_q[`EMM_CTRL_BREG];
  wire [1:0] oreg   = ctrl_q[`EMM_CTRL_OREG];
  wire [1:0] sreg   = ctrl_q[`EMM_CTRL_SREG];
  // Wide mode drives both halves of an operand from its low-half option
  wire [1:0] areg_e = narrow ? areg : {areg[0], areg[0]};
  wire [1:0] breg_e = narrow ? breg : {breg[0], breg[0]};
  wire [1:0] oreg_e = narrow ? oreg : {oreg[0], oreg[0]};

  // ***************************************************************
  // Sign select stages
  // ***************************************************************
  wire sa;
  wire sb;

  emm_stage #(.W(1)) u_sa (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (mul_ce),
    .use_reg (sreg[0]),
    .d       (sign_a),
    .q       (sa)
  );

  emm_stage #(.W(1)) u_sb (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (mul_ce),
    .use_reg (sreg[1]),
    .d       (sign_b),
    .q       (sb)
  );

  // ***************************************************************
  // Operand stages, one per half
  // ***************************************************************
  wire [17:0] op_a;
  wire [17:0] op_b;

  genvar h;
  generate
    for (h = 0; h < 2; h = h + 1) begin : g_in
      emm_stage #(.W(`EMM_HALF_W)) u_a (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (mul_ce),
        .use_reg (areg_e[h]),
        .d       (data_a[h*`EMM_HALF_W +: `EMM_HALF_W]),
        .q       (op_a[h*`EMM_HALF_W +: `EMM_HALF_W])
      );
      emm_stage #(.W(`EMM_HALF_W)) u_b (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (mul_ce),
        .use_reg (breg_e[h]),
        .d       (data_b[h*`EMM_HALF_W +: `EMM_HALF_W]),
        .q       (op_b[h*`EMM_HALF_W +: `EMM_HALF_W])
      );
    end
  endgenerate

  // ***************************************************************
  // Multiplier core
  // ***************************************************************
  function [4:0] clamp_w;
    input [4:0] w;
    begin
      if (w < `EMM_WID_MIN) begin
        clamp_w = `EMM_WID_MIN;
      end else if (w > `EMM_WID_MAX) begin
        clamp_w = `EMM_WID_MAX;
      end else begin
        clamp_w = w;
      end
    end
  endfunction

  // Keeps the low w bits, fills above with sign or zero
  function [18:0] ext_op;
    input [17:0] v;
    input [4:0]  w;
    input        s;
    integer i;
    reg     msb;
    begin
      msb    = v[w-5'h01];
      ext_op = 19'h00000;
      for (i = 0; i < 19; i = i + 1) begin
        ext_op[i] = (i < w) ? v[i] : (s & msb);
      end
    end
  endfunction

  wire [4:0]         wa   = clamp_w(wid_a_q);
  wire [4:0]         wb   = clamp_w(wid_b_q);
  wire signed [18:0] xa   = ext_op(op_a, wa, sa);
  wire signed [18:0] xb   = ext_op(op_b, wb, sb);
  wire signed [37:0] pw   = xa * xb;
  wire signed [9:0]  xa0  = {sa & op_a[8], op_a[8:0]};
  wire signed [9:0]  xb0  = {sb & op_b[8], op_b[8:0]};
  wire signed [9:0]  xa1  = {sa & op_a[17], op_a[17:9]};
  wire signed [9:0]  xb1  = {sb & op_b[17], op_b[17:9]};
  wire signed [19:0] pn0  = xa0 * xb0;
  wire signed [19:0] pn1  = xa1 * xb1;
  wire [35:0] raw = narrow ? {pn1[17:0], pn0[17:0]} : pw[35:0];

  // ***************************************************************
  // Product stages, 18-bit sections joined in wide mode
  // ***************************************************************
  wire [35:0] pst;

  generate
    for (h = 0; h < 2; h = h + 1) begin : g_out
      emm_stage #(.W(`EMM_HPROD_W)) u_p (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (mul_ce),
        .use_reg (oreg_e[h]),
        .d       (raw[h*`EMM_HPROD_W +: `EMM_HPROD_W]),
        .q       (pst[h*`EMM_HPROD_W +: `EMM_HPROD_W])
      );
    end
  endgenerate

  // Sign flag follows the low product section, so it matches the whole product only while both oreg_e bits agree
  wire psg;

  emm_stage #(.W(1)) u_ps (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (mul_ce),
    .use_reg (oreg_e[0]),
    .d       (sa | sb),
    .q       (psg)
  );

  // ***************************************************************
  // Fabric-facing output flops
  // ***************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prod_q <= 36'h000000000;
      psgn_q <= 1'b0;
    end else if (mul_ce) begin
      prod_q <= pst;
      psgn_q <= psg;
    end
  end

  assign product        = prod_q;
  assign product_signed = psgn_q;
endmodule
